//--- srst_defines.vh
// Constants for the soft reset controller
`ifndef SRST_DEFINES_VH
`define SRST_DEFINES_VH
// Register byte addresses
`define SRST_ADDR_CTRL     12'h000
`define SRST_ADDR_KEY      12'h004
`define SRST_ADDR_STATUS   12'h008
// Control register fields
`define SRST_BIT_FULL      0
`define SRST_BIT_PHYRST    1
`define SRST_BIT_PWRDN     2
// Key pair for MAC reset
`define SRST_KEY_FIRST     16'h4f1c
`define SRST_KEY_SECOND    16'hc1f4
// Timing, in ns, and clock period
`define SRST_CLK_NS        8
`define SRST_PULSE_NS      1200
`define SRST_FULL_NS       10000000
`define SRST_PULSE_CYC     ((`SRST_PULSE_NS + `SRST_CLK_NS - 1) / `SRST_CLK_NS)
`define SRST_PULSE_W       8
`define SRST_FULL_CYC      (`SRST_FULL_NS / `SRST_CLK_NS)
`define SRST_OSC_CYC       (`SRST_FULL_CYC / 2)
`define SRST_PLL_CYC       (`SRST_FULL_CYC / 4)
// Full reset sequencer states
`define SRST_ST_IDLE       3'h0
`define SRST_ST_TRI        3'h1
`define SRST_ST_OSC        3'h2
`define SRST_ST_PLL        3'h3
`define SRST_ST_REL        3'h4
`endif

//--- srst_pulse.v
// Fixed-length reset pulse generator
`timescale 1ns/1ps
module srst_pulse
#(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] LENGTH = 8'h96
)
(
  input  wire             pclk,
  input  wire             presetn,
  input  wire             start,
  output reg              active
);
  reg [WIDTH-1:0] count;

  // Count down the pulse from start
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count  <= {WIDTH{1'b0}};
      active <= 1'b0;
    end
    else if (start && !active)
    begin
      count  <= LENGTH - {{(WIDTH-1){1'b0}}, 1'b1};
      active <= 1'b1;
    end
    else if (active)
    begin
      if (count == {WIDTH{1'b0}})
        active <= 1'b0;
      else
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // srst_pulse

//--- srst_ctrl.v
// Soft reset controller with APB register slave
`timescale 1ns/1ps
`include "srst_defines.vh"
module srst_ctrl
#(
  parameter FULL_CYC = `SRST_FULL_CYC,
  parameter OSC_CYC  = `SRST_OSC_CYC,
  parameter PLL_CYC  = `SRST_PLL_CYC
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        osc_stable,
  input  wire        pll_locked,
  input  wire [3:0]  strap_pins,
  input  wire        spi_sdo_func,
  input  wire        timestamp_timer_func,
  output reg         spi_sdo,
  output reg         timestamp_timer_pin,
  output reg         io_tristate,
  output reg  [3:0]  strap_latched,
  output reg         osc_enable,
  output reg         pll_enable,
  output reg         core_reset,
  output reg         mac_reset,
  output reg         phy_reset,
  output reg         tx_abort,
  output reg         link_bringup
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  // Synchronised clock status and strap pins
  reg  [1:0]  osc_sync;
  reg  [1:0]  pll_sync;
  reg  [3:0]  strap_s1;
  reg  [3:0]  strap_s2;
  // Full reset sequencer
  reg  [2:0]  fstate;
  reg  [2:0]  next_fstate;
  reg  [23:0] fcount;
  // Register state and pulse requests
  reg         soft_powerdown_request;
  reg         key_armed;
  reg         mac_start;
  reg         phy_start;
  wire        mac_busy;
  wire        phy_busy;
  // APB decode
  wire        acc;
  wire        wr;
  wire        rd;
  wire        full_go;
  wire        status_clear;

  // Pulse timer sizing, cut to the timer width on purpose
  localparam        PULSE_W   = `SRST_PULSE_W;
  localparam [31:0] PULSE_CYC = `SRST_PULSE_CYC;

  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;
  assign full_go = wr && (paddr == `SRST_ADDR_CTRL) && pwdata[`SRST_BIT_FULL];
  // Old clock status must drain, or fcount reach PLL_CYC, before the oscillator restarts
  assign status_clear = !osc_sync[1] && !pll_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  // Clock status and straps are asynchronous to pclk
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_sync <= 2'h0;
      pll_sync <= 2'h0;
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
    end
    else
    begin
      osc_sync <= {osc_sync[0], osc_stable};
      pll_sync <= {pll_sync[0], pll_locked};
      strap_s1 <= strap_pins;
      strap_s2 <= strap_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Full chip reset sequencer next state
  // Every wait has a timeout so a dead oscillator cannot hold the chip
  always @*
  begin
    next_fstate = fstate;
    case (fstate)
      `SRST_ST_IDLE: if (full_go) next_fstate = `SRST_ST_TRI;
      `SRST_ST_TRI:  if (status_clear || fcount >= PLL_CYC) next_fstate = `SRST_ST_OSC;
      `SRST_ST_OSC:  if (osc_sync[1] || fcount >= OSC_CYC) next_fstate = `SRST_ST_PLL;
      `SRST_ST_PLL:  if (pll_sync[1] || fcount >= OSC_CYC + PLL_CYC)
                       next_fstate = `SRST_ST_REL;
      `SRST_ST_REL:  next_fstate = `SRST_ST_IDLE;
      default:       next_fstate = `SRST_ST_IDLE;
    endcase
  end

  // Sequencer registers and pin control
  // fcount times the fallback waits from the request on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fstate        <= `SRST_ST_IDLE;
      fcount        <= 24'h000000;
      io_tristate   <= 1'b0;
      strap_latched <= 4'h0;
      osc_enable    <= 1'b1;
      pll_enable    <= 1'b1;
      core_reset    <= 1'b0;
      tx_abort      <= 1'b0;
      link_bringup  <= 1'b1;
    end
    else
    begin
      fstate   <= next_fstate;
      tx_abort <= full_go;
      if (fstate == `SRST_ST_IDLE)
        fcount <= 24'h000000;
      else
        fcount <= fcount + 24'h000001;
      case (fstate)
        `SRST_ST_IDLE:
        begin
          // Request drops clocks and floats pins at once
          if (full_go)
          begin
            core_reset   <= 1'b1;
            io_tristate  <= 1'b1;
            osc_enable   <= 1'b0;
            pll_enable   <= 1'b0;
            link_bringup <= 1'b0;
          end
        end
        `SRST_ST_TRI:
        begin
          // Straps sampled while pins float, then pins return to duty
          if (next_fstate == `SRST_ST_OSC)
          begin
            strap_latched <= strap_s2;
            io_tristate   <= 1'b0;
            osc_enable    <= 1'b1;
          end
        end
        `SRST_ST_OSC:
        begin
          // PLL starts on fresh oscillator status or once fcount reaches OSC_CYC
          if (next_fstate == `SRST_ST_PLL)
            pll_enable <= 1'b1;
        end
        `SRST_ST_REL:
        begin
          // Bring-up follows release unless power-down is pending
          core_reset   <= 1'b0;
          link_bringup <= !soft_powerdown_request;
        end
        default:
        begin
          core_reset <= core_reset;
        end
      endcase
      // Outside a full reset, bring-up tracks the power-down request
      if (fstate == `SRST_ST_IDLE && !core_reset)
        link_bringup <= !soft_powerdown_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key check and control register writes
  // Full reset bit is never stored, so it always reads zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_powerdown_request <= 1'b0;
      key_armed              <= 1'b0;
      mac_start              <= 1'b0;
      phy_start              <= 1'b0;
    end
    else
    begin
      mac_start <= 1'b0;
      phy_start <= 1'b0;
      if (wr && paddr == `SRST_ADDR_KEY)
      begin
        // Second key only counts straight after the first
        if (key_armed && pwdata[15:0] == `SRST_KEY_SECOND)
          mac_start <= !soft_powerdown_request;
        key_armed <= (pwdata[15:0] == `SRST_KEY_FIRST);
      end
      // Any other write between the two keys disarms the pair
      else if (wr)
        key_armed <= 1'b0;
      if (wr && paddr == `SRST_ADDR_CTRL)
      begin
        soft_powerdown_request <= pwdata[`SRST_BIT_PWRDN];
        phy_start <= pwdata[`SRST_BIT_PHYRST];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse timers
  // One timer design serves both the MAC and the PHY pulse
  srst_pulse
  #(
    .WIDTH  (PULSE_W),
    .LENGTH (PULSE_CYC[PULSE_W-1:0])
  )
  u_mac_pulse
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (mac_start),
    .active  (mac_busy)
  );

  srst_pulse
  #(
    .WIDTH  (PULSE_W),
    .LENGTH (PULSE_CYC[PULSE_W-1:0])
  )
  u_phy_pulse
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (phy_start),
    .active  (phy_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset outputs and pins held low while MAC in reset
  // Pins follow functional logic one cycle late; full reset forces both
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mac_reset           <= 1'b0;
      phy_reset           <= 1'b0;
      spi_sdo             <= 1'b0;
      timestamp_timer_pin <= 1'b0;
    end
    else
    begin
      mac_reset <= mac_busy || core_reset;
      phy_reset <= phy_busy || core_reset;
      if (mac_busy || core_reset)
      begin
        spi_sdo             <= 1'b0;
        timestamp_timer_pin <= 1'b0;
      end
      else
      begin
        spi_sdo             <= spi_sdo_func;
        timestamp_timer_pin <= timestamp_timer_func;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: pready in the first access cycle, reads served during PHY reset
  // Read data is registered at setup and held through the access edge
  // Unmapped addresses answer with an error and read as zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != `SRST_ADDR_CTRL &&
                 paddr != `SRST_ADDR_KEY && paddr != `SRST_ADDR_STATUS;
      prdata  <= 32'h00000000;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == `SRST_ADDR_CTRL)
          prdata <= {29'h0, soft_powerdown_request, phy_busy, 1'b0};
        else if (paddr == `SRST_ADDR_STATUS)
          prdata <= {25'h0, strap_latched, link_bringup, mac_busy, core_reset};
      end
      if (rd)
        prdata <= prdata;
    end
  end
endmodule // srst_ctrl

//--- srst_checker.sv
// Port assertions for the soft reset controller
`timescale 1ns/1ps
`include "srst_defines.vh"
module srst_checker
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        io_tristate,
  input wire        osc_stable,
  input wire        osc_enable,
  input wire        pll_enable,
  input wire        core_reset,
  input wire        mac_reset,
  input wire        phy_reset,
  input wire        tx_abort,
  input wire        spi_sdo,
  input wire        timestamp_timer_pin
);
  reg  [8:0] mlen;
  reg  [8:0] plen;
  wire       key_ok;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted write of the second key
  assign key_ok = psel && penable && pready && pwrite && paddr == `SRST_ADDR_KEY
                  && pwdata[15:0] == `SRST_KEY_SECOND;
  // Lengths of the MAC and PHY reset pulses
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mlen <= 9'h000;
      plen <= 9'h000;
    end
    else
    begin
      mlen <= mac_reset ? mlen + 9'h001 : 9'h000;
      plen <= phy_reset ? plen + 9'h001 : 9'h000;
    end
  sequence s_full_go;
    $rose(core_reset) ##0 tx_abort;
  endsequence
  property p_tri; $rose(core_reset) |-> io_tristate; endproperty
  a_tri: assert property (p_tri) else $error("pins not tristated");
  property p_abort; s_full_go |=> !tx_abort; endproperty
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  property p_rel; $rose(core_reset) |-> ##[1:200] !core_reset; endproperty
  a_rel: assert property (p_rel) else $error("full reset too long");
  property p_pll; $rose(pll_enable) |-> osc_enable && osc_stable; endproperty
  a_pll: assert property (p_pll) else $error("pll before osc");
  property p_sdo; mac_reset && $past(mac_reset) |-> !spi_sdo && !timestamp_timer_pin; endproperty
  a_sdo: assert property (p_sdo) else $error("pins not low in mac reset");
  property p_mac;
    $fell(mac_reset) && !$past(core_reset, 2) |-> mlen == `SRST_PULSE_CYC;
  endproperty
  a_mac: assert property (p_mac) else $error("mac pulse length");
  property p_phy;
    $fell(phy_reset) && !$past(core_reset, 2) |-> plen == `SRST_PULSE_CYC;
  endproperty
  a_phy: assert property (p_phy) else $error("phy pulse length");
  property p_key;
    $rose(mac_reset) && !core_reset |-> $past(key_ok, 3) || $past(key_ok, 4);
  endproperty
  a_key: assert property (p_key) else $error("mac reset without key");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
endmodule // srst_checker

//--- srst_clk_model.sv
// Oscillator and PLL model answering the sequencer
`timescale 1ns/1ps
module srst_clk_model
(
  input  wire pclk,
  input  wire presetn,
  input  wire osc_enable,
  input  wire pll_enable,
  output reg  osc_stable,
  output reg  pll_locked
);
  reg [3:0] ocnt;
  // Oscillator settles after start-up, PLL locks only on it
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ocnt <= 4'h0;
      osc_stable <= 1'b0;
      pll_locked <= 1'b0;
    end
    else
    begin
      ocnt <= osc_enable ? ocnt + {3'h0, ocnt != 4'hf} : 4'h0;
      osc_stable <= osc_enable && ocnt > 4'h6;
      pll_locked <= pll_enable && osc_stable;
    end
endmodule // srst_clk_model

//--- tb_top.sv
// Testbench for the soft reset controller
`timescale 1ns/1ps
`include "srst_defines.vh"
module tb_top;
  reg         pclk, presetn, psel, penable, pwrite, spi_sdo_func, timestamp_timer_func;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rdat;
  reg  [3:0]  strap_pins;
  reg         rerr;
  wire [31:0] prdata;
  wire [3:0]  strap_latched;
  wire        pready, pslverr, osc_stable, pll_locked, spi_sdo, timestamp_timer_pin;
  wire        io_tristate, osc_enable, pll_enable, core_reset, mac_reset, phy_reset;
  wire        tx_abort, link_bringup;
  integer     n_mismatch, samples_checked, j;
  srst_ctrl #(.FULL_CYC(40), .OSC_CYC(20), .PLL_CYC(10)) dut_u (.*);
  srst_clk_model clk_u (.*);
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // One APB transfer, held until pready
  task apb(input [11:0] a, input w, input [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait for the slave; only the watchdog ends a hung transfer
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task keys(input [15:0] k);
  begin
    apb(`SRST_ADDR_KEY, 1'b1, {16'h0000, `SRST_KEY_FIRST});
    apb(`SRST_ADDR_KEY, 1'b1, {16'h0000, k});
    repeat (5) @(posedge pclk);
  end
  endtask
  task wrap_up;
  begin
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {spi_sdo_func, timestamp_timer_func} = 2'b11;
    strap_pins = 4'ha;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(`SRST_ADDR_STATUS, 1'b0, 0);
    chk(rdat, 32'h4);
    apb(12'h00c, 1'b0, 0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    apb(`SRST_ADDR_CTRL, 1'b1, 32'h2);
    apb(`SRST_ADDR_CTRL, 1'b0, 0);
    chk(rdat, 32'h2);
    chk(phy_reset, 1);
    repeat (160) @(posedge pclk);
    apb(`SRST_ADDR_CTRL, 1'b0, 0);
    chk({rdat[30:0], phy_reset}, 32'h0);
    keys(16'h1234);
    chk(mac_reset, 0);
    keys(`SRST_KEY_SECOND);
    chk(mac_reset, 1);
    chk({spi_sdo, timestamp_timer_pin, link_bringup}, 3'b001);
    repeat (160) @(posedge pclk);
    chk({mac_reset, spi_sdo}, 2'b01);
    apb(`SRST_ADDR_CTRL, 1'b1, 32'h4);
    keys(`SRST_KEY_SECOND);
    chk({mac_reset, link_bringup}, 0);
    apb(`SRST_ADDR_CTRL, 1'b1, 0);
    repeat (2) @(posedge pclk);
    chk(link_bringup, 1);
    apb(`SRST_ADDR_CTRL, 1'b1, 32'h1);
    chk(core_reset, 1);
    chk(tx_abort, 1);
    chk(io_tristate, 1);
    chk({osc_enable, pll_enable}, 2'b00);
    for (j = 0; j < 300 && core_reset !== 1'b0; j = j + 1)
      @(posedge pclk);
    chk(core_reset, 0);
    chk(strap_latched, 4'ha);
    chk({osc_enable, pll_enable, io_tristate}, 3'b110);
    chk(link_bringup, 1);
    apb(`SRST_ADDR_CTRL, 1'b0, 0);
    chk(rdat, 0);
    wrap_up;
  end
  // Watchdog
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
endmodule // tb_top
bind srst_ctrl srst_checker chk_u (.*);
